// ===== pkg/speed_mon_pkg.sv
// constants for the start/stop sequencer and speed monitor
// Functional notes
// - base clock period is 195.3 microseconds
// - prescaler divides by five or eight
// - standard build clears at five, advances counter
// - low-speed option clears at eight instead
// - 8-bit counter; index clears all counting
// - counter stops at 64 until index
// - coarse flag loads not-64 at index
// - tick at count 26 or more sets late
// - 95 percent flag set if late clear
// - within-2 flag set if count equals 24
// - within-2 low drops heads loaded, ready
// - 95 percent low drops head hold
// - speed flags cleared while run latch reset
// - load mode with brushes home sets permit
// - run sets request; brush drive sequencing
// - brush drive gates two antiphase 60 Hz
// - brush drive blocks head hold; permit clear
// - park delay holds spindle 200 ms
// - delay end: permit, retract, spindle off
// - carriage parked asserts release tray low
// - run refused without cartridge, drawer closed
// - head hold starts 1.4 s pick pulse
// - loaded needs within-2, hold, pick expired
// - hold drops on slow, brush, off media
package speed_mon_pkg;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned BASE_PERIOD_NS = 195300;
   localparam int unsigned BASE_CYCLES = BASE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int unsigned PARK_DELAY_MS = 200;
   localparam int unsigned PARK_CYCLES =
      PARK_DELAY_MS * (1000000 / CLK_PERIOD_NS);
   localparam int unsigned PICK_TIME_MS = 1400;
   localparam int unsigned PICK_CYCLES =
      PICK_TIME_MS * (1000000 / CLK_PERIOD_NS);
   localparam int unsigned SWEEP_HZ = 60;
   localparam int unsigned SWEEP_HALF_CYCLES =
      1000000000 / (2 * SWEEP_HZ * CLK_PERIOD_NS);
   localparam logic [3:0] PRE_WRAP_STD = 4'h5;
   localparam logic [3:0] PRE_WRAP_LOW = 4'h8;
   localparam logic [7:0] CNT_STOP = 8'h40;
   localparam logic [7:0] CNT_LATE = 8'h1a;
   localparam logic [7:0] CNT_WITHIN = 8'h18;
   localparam int unsigned SYNC_W = 7;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_COUNT = 4'h2;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int unsigned CTRL_LOW_SPEED = 0;
endpackage : speed_mon_pkg

// ===== hdl/cycle_timer.sv
// one-shot or repeating cycle timer with busy level and done pulse
`timescale 1ns/1ps
`default_nettype none
module cycle_timer #(
   parameter int unsigned CYCLES = 1
) (
   input wire logic i_mclk, // system clock
   input wire logic i_reset, // async reset, active high
   input wire logic i_start, // load and run, also restarts
   input wire logic i_repeat, // reload on expiry
   output logic o_busy, // timer running
   output logic o_done // one-cycle pulse on expiry
);
   localparam logic [27:0] LOAD = 28'(CYCLES - 1);
   logic [27:0] cnt_q;

   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
      begin
         cnt_q <= 28'h0;
         o_busy <= 1'b0;
         o_done <= 1'b0;
      end
      else
      begin
         o_done <= 1'b0;
         if (i_start)
         begin
            cnt_q <= LOAD;
            o_busy <= 1'b1;
         end
         else if (o_busy)
         begin
            if (cnt_q == 28'h0)
            begin
               o_done <= 1'b1;
               o_busy <= i_repeat;
               cnt_q <= LOAD;
            end
            else
               cnt_q <= cnt_q - 28'h1;
         end
      end
   end
endmodule : cycle_timer
`default_nettype wire

// ===== hdl/speed_monitor.sv
// start/stop sequencer and spindle speed monitor
`timescale 1ns/1ps
`default_nettype none
module speed_monitor
   import speed_mon_pkg::*;
#(
   parameter int unsigned BASE_CYC = BASE_CYCLES,
   parameter int unsigned PARK_CYC = PARK_CYCLES,
   parameter int unsigned PICK_CYC = PICK_CYCLES,
   parameter int unsigned SWEEP_CYC = SWEEP_HALF_CYCLES
) (
   input wire logic i_mclk, // 100 MHz clock
   input wire logic i_reset, // async reset, active high
   input wire logic i_run_sel, // load/run switch, high = run
   input wire logic i_cart_present, // cartridge installed
   input wire logic i_drawer_closed, // equipment drawer closed
   input wire logic i_brush_home, // sweepers parked
   input wire logic i_over_media, // carriage over media
   input wire logic i_carriage_parked, // carriage fully retracted
   input wire logic i_index, // once-per-revolution mark
   input wire logic [3:0] i_addr, // register address
   input wire logic [7:0] i_wdata, // register write data
   input wire logic i_wr, // write strobe
   input wire logic i_rd, // read strobe
   output logic [7:0] o_rdata, // read data, one cycle after strobe
   output logic o_spindle_enable, // spindle permit and power
   output logic o_high_power, // spindle high-power mode
   output logic o_heads_extend, // move carriage toward track zero
   output logic o_head_hold, // head-load hold current
   output logic o_head_pick, // head-load pick current
   output logic o_heads_loaded, // heads loaded
   output logic o_unit_ready, // unit ready and panel lamp
   output logic o_brush_a, // brush motor phase a
   output logic o_brush_b, // brush motor phase b
   output logic o_release_tray_n // drawer release enable, low active
);
   logic [SYNC_W-1:0] s1_q;
   logic [SYNC_W-1:0] s2_q;
   logic idx_prev_q;
   logic idx_ev;
   logic run_sel, cart, drawer, home, over, parked;
   logic [7:0] ctrl_q;
   logic low_speed;
   logic base_tick;
   logic [3:0] pre_q;
   logic [3:0] pre_d;
   logic adv_q;
   logic [7:0] cnt_q;
   logic late_q;
   logic coarse_q, fast_q, within_q;
   logic spin_run_q, spin_prev_q;
   logic allow_q;
   logic brush_drv_q, brush_left_q, brush_done_q;
   logic hold_q, hold_prev_q;
   logic pick_busy, pick_done, pick_exp_q;
   logic park_busy, park_done;
   logic sweep_done, sweep_busy;
   logic sq_q;
   logic release_q;
   logic loaded_q;

   // two-flop synchronisers for all switch and sensor pins
   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
      begin
         s1_q <= '0;
         s2_q <= '0;
         idx_prev_q <= 1'b0;
      end
      else
      begin
         s1_q <= {i_index, i_carriage_parked, i_over_media, i_brush_home,
                  i_drawer_closed, i_cart_present, i_run_sel};
         s2_q <= s1_q;
         idx_prev_q <= s2_q[6];
      end
   end

   assign run_sel = s2_q[0];
   assign cart = s2_q[1];
   assign drawer = s2_q[2];
   assign home = s2_q[3];
   assign over = s2_q[4];
   assign parked = s2_q[5];
   assign idx_ev = s2_q[6] & ~idx_prev_q;
   assign low_speed = ctrl_q[CTRL_LOW_SPEED];

   // base clock generator, restarted by each index mark
   cycle_timer #(.CYCLES(BASE_CYC)) u_base (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_start(idx_ev),
      .i_repeat(1'b1),
      .o_busy(),
      .o_done(base_tick)
   );

   // prescaler: wrap at five or, with the option, at eight
   always_comb
   begin
      pre_d = pre_q + 4'h1;
   end

   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
      begin
         pre_q <= 4'h0;
         adv_q <= 1'b0;
      end
      else
      begin
         adv_q <= 1'b0;
         if (idx_ev)
            pre_q <= 4'h0;
         else if (base_tick)
         begin
            if (pre_d == (low_speed ? PRE_WRAP_LOW : PRE_WRAP_STD))
            begin
               pre_q <= 4'h0;
               adv_q <= 1'b1;
            end
            else
               pre_q <= pre_d;
         end
      end
   end

   // revolution counter and late-revolution flop
   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
      begin
         cnt_q <= 8'h0;
         late_q <= 1'b0;
      end
      else if (idx_ev)
      begin
         cnt_q <= 8'h0;
         late_q <= 1'b0;
      end
      else if (adv_q)
      begin
         if (cnt_q != CNT_STOP)
            cnt_q <= cnt_q + 8'h1;
         if (cnt_q >= CNT_LATE)
            late_q <= 1'b1;
      end
   end

   // speed flags, loaded at index, held clear while not running
   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
      begin
         coarse_q <= 1'b0;
         fast_q <= 1'b0;
         within_q <= 1'b0;
      end
      else if (!spin_run_q)
      begin
         coarse_q <= 1'b0;
         fast_q <= 1'b0;
         within_q <= 1'b0;
      end
      else if (idx_ev)
      begin
         coarse_q <= (cnt_q != CNT_STOP);
         fast_q <= ~late_q;
         within_q <= (cnt_q == CNT_WITHIN);
      end
   end

   // spindle-rotate request latch
   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
      begin
         spin_run_q <= 1'b0;
         spin_prev_q <= 1'b0;
      end
      else
      begin
         spin_prev_q <= spin_run_q;
         if (!run_sel)
            spin_run_q <= 1'b0;
         else if (cart && drawer && !park_busy)
            spin_run_q <= 1'b1;
      end
   end

   // park-hold delay after the request drops
   cycle_timer #(.CYCLES(PARK_CYC)) u_park (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_start(spin_prev_q & ~spin_run_q),
      .i_repeat(1'b0),
      .o_busy(park_busy),
      .o_done(park_done)
   );

   // sweep permit and brush cycle
   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
         allow_q <= 1'b0;
      else if (park_done || (!run_sel && home && !spin_run_q))
         allow_q <= 1'b1;
      else if (brush_drv_q)
         allow_q <= 1'b0;
   end

   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
      begin
         brush_drv_q <= 1'b0;
         brush_left_q <= 1'b0;
         brush_done_q <= 1'b0;
      end
      else if (!spin_run_q)
      begin
         brush_drv_q <= brush_drv_q & ~home;
         brush_left_q <= 1'b0;
         brush_done_q <= 1'b0;
      end
      else if (brush_drv_q)
      begin
         if (!home)
            brush_left_q <= 1'b1;
         else if (brush_left_q)
         begin
            brush_drv_q <= 1'b0;
            brush_done_q <= 1'b1;
         end
      end
      else if (allow_q && home)
         brush_drv_q <= 1'b1;
   end

   // 60 Hz square wave source
   cycle_timer #(.CYCLES(SWEEP_CYC)) u_sweep (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_start(~sweep_busy),
      .i_repeat(1'b1),
      .o_busy(sweep_busy),
      .o_done(sweep_done)
   );

   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
         sq_q <= 1'b0;
      else if (sweep_done)
         sq_q <= ~sq_q;
   end

   // head-land hold, pick pulse and heads-loaded
   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
      begin
         hold_q <= 1'b0;
         hold_prev_q <= 1'b0;
      end
      else
      begin
         hold_prev_q <= hold_q;
         hold_q <= spin_run_q & fast_q & ~brush_drv_q & over &
                   brush_done_q;
      end
   end

   cycle_timer #(.CYCLES(PICK_CYC)) u_pick (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_start(hold_q & ~hold_prev_q),
      .i_repeat(1'b0),
      .o_busy(pick_busy),
      .o_done(pick_done)
   );

   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
         pick_exp_q <= 1'b0;
      else if (!hold_q)
         pick_exp_q <= 1'b0;
      else if (pick_done)
         pick_exp_q <= 1'b1;
   end

   assign loaded_q = within_q & hold_q & pick_exp_q;

   // release tray once the carriage is parked after a stop
   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
         release_q <= 1'b0;
      else
         release_q <= parked & ~spin_run_q & ~park_busy;
   end

   // control register and read port
   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
         ctrl_q <= CTRL_RESET;
      else if (i_wr && i_addr == REG_CTRL)
         ctrl_q <= i_wdata;
   end

   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
         o_rdata <= 8'h0;
      else if (i_rd)
      begin
         case (i_addr)
            REG_CTRL: o_rdata <= ctrl_q;
            REG_STATUS: o_rdata <= {spin_run_q, allow_q, brush_drv_q,
                                    hold_q, loaded_q, within_q, fast_q,
                                    coarse_q};
            REG_COUNT: o_rdata <= cnt_q;
            default: o_rdata <= 8'h0;
         endcase
      end
      else
         o_rdata <= 8'h0;
   end

   // registered outputs
   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
      begin
         o_spindle_enable <= 1'b0;
         o_high_power <= 1'b0;
         o_heads_extend <= 1'b0;
         o_head_hold <= 1'b0;
         o_head_pick <= 1'b0;
         o_heads_loaded <= 1'b0;
         o_unit_ready <= 1'b0;
         o_brush_a <= 1'b0;
         o_brush_b <= 1'b0;
         o_release_tray_n <= 1'b1;
      end
      else
      begin
         o_spindle_enable <= spin_run_q | park_busy;
         o_high_power <= coarse_q;
         o_heads_extend <= spin_run_q | park_busy;
         o_head_hold <= hold_q;
         o_head_pick <= hold_q & pick_busy;
         o_heads_loaded <= loaded_q;
         o_unit_ready <= loaded_q;
         o_brush_a <= brush_drv_q & sq_q;
         o_brush_b <= brush_drv_q & ~sq_q;
         o_release_tray_n <= ~release_q;
      end
   end

   a_count_stops: assert property (@(posedge i_mclk) disable iff (i_reset)
      (cnt_q == CNT_STOP && !idx_ev) |=> (cnt_q == CNT_STOP))
      else $error("revolution count moved past stop value");

   a_index_clears: assert property (@(posedge i_mclk) disable iff (i_reset)
      idx_ev |=> (cnt_q == 8'h0 && pre_q == 4'h0 && !late_q))
      else $error("index did not clear counting");

   a_coarse_load: assert property (@(posedge i_mclk) disable iff (i_reset)
      (idx_ev && spin_run_q && run_sel) |=>
      (coarse_q == ($past(cnt_q) != CNT_STOP)))
      else $error("coarse flag loaded wrong value");

   a_fast_load: assert property (@(posedge i_mclk) disable iff (i_reset)
      (idx_ev && spin_run_q && run_sel) |=> (fast_q != $past(late_q)))
      else $error("95 percent flag loaded wrong value");

   a_within_load: assert property (@(posedge i_mclk) disable iff (i_reset)
      (idx_ev && spin_run_q && run_sel) |=>
      (within_q == ($past(cnt_q) == CNT_WITHIN)))
      else $error("within flag loaded wrong value");

   a_flags_clear: assert property (@(posedge i_mclk) disable iff (i_reset)
      !spin_run_q |=> !(coarse_q || fast_q || within_q))
      else $error("speed flag set while not running");

   a_hold_blocked: assert property (@(posedge i_mclk) disable iff (i_reset)
      (brush_drv_q || !fast_q || !over) |=> !hold_q)
      else $error("head hold asserted while blocked");

   a_loaded_cause: assert property (@(posedge i_mclk) disable iff (i_reset)
      o_heads_loaded |-> $past(within_q) && $past(pick_exp_q))
      else $error("heads loaded without cause");

   a_run_refused: assert property (@(posedge i_mclk) disable iff (i_reset)
      (!spin_run_q && !(cart && drawer)) |=> !spin_run_q)
      else $error("run entered without cartridge or drawer");

   a_brush_antiphase: assert property (@(posedge i_mclk) disable iff (i_reset)
      !(o_brush_a && o_brush_b))
      else $error("brush phases overlap");

   a_brush_gated: assert property (@(posedge i_mclk) disable iff (i_reset)
      !brush_drv_q |=> (!o_brush_a && !o_brush_b))
      else $error("brush phase driven without brush drive");
endmodule : speed_monitor
`default_nettype wire

// ===== verif/spindle_sensors.sv
// sensor, carriage and spindle driver model facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module spindle_sensors #(
   parameter int unsigned AWAY = 3000
) (
   input wire logic i_mclk, // clock
   input wire logic i_reset, // async reset, active high
   input wire logic [15:0] i_period, // index period in clocks, 0 = still
   input wire logic i_media_block, // pull carriage off media
   input wire logic i_spindle_enable, // spindle power
   input wire logic i_heads_extend, // carriage forward
   input wire logic i_brush_a, // brush phase a
   input wire logic i_brush_b, // brush phase b
   input wire logic i_release_tray_n, // release enable, low active
   output logic o_index, // index mark
   output logic o_brush_home, // sweepers parked
   output logic o_over_media, // carriage over media
   output logic o_carriage_parked, // carriage retracted
   output logic o_unlock // drawer solenoid energised
);
   logic [15:0] idx_q;
   logic [15:0] away_q;
   logic armed_q;
   logic [7:0] car_q;
   logic [7:0] stop_q;
   assign o_index = (i_period != 16'h0000) && (idx_q < 16'h0003);
   assign o_brush_home = (away_q == 16'h0000);
   assign o_over_media = (car_q == 8'h28) && !i_media_block;
   assign o_carriage_parked = (car_q == 8'h00);
   // solenoid needs a stopped spindle and the release enable together
   assign o_unlock = (stop_q == 8'h64) && !i_release_tray_n;
   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
      begin
         idx_q <= 16'h0000;
         away_q <= 16'h0000;
         armed_q <= 1'b1;
         car_q <= 8'h00;
         stop_q <= 8'h00;
      end
      else
      begin
         if (i_period == 16'h0000 || idx_q >= i_period - 16'h0001)
            idx_q <= 16'h0000;
         else
            idx_q <= idx_q + 16'h0001;
         // one excursion per drive burst; rearm once drive is gone
         if (away_q != 16'h0000)
            away_q <= away_q - 16'h0001;
         else if ((i_brush_a || i_brush_b) && armed_q)
            away_q <= 16'(AWAY);
         if (!(i_brush_a || i_brush_b))
            armed_q <= 1'b1;
         else if (away_q != 16'h0000)
            armed_q <= 1'b0;
         if (i_heads_extend && car_q != 8'h28)
            car_q <= car_q + 8'h01;
         else if (!i_heads_extend && car_q != 8'h00)
            car_q <= car_q - 8'h01;
         if (i_spindle_enable)
            stop_q <= 8'h00;
         else if (stop_q != 8'h64)
            stop_q <= stop_q + 8'h01;
      end
   end
endmodule : spindle_sensors
`default_nettype wire

// ===== verif/tb_speed_monitor.sv
// self-checking bench for the sequencer and speed monitor
`timescale 1ns/1ps
`default_nettype none
module tb_speed_monitor;
   import speed_mon_pkg::*;
   logic i_mclk, i_reset, i_run_sel, i_cart_present, i_drawer_closed;
   logic i_wr, i_rd, media_block;
   logic [3:0] i_addr;
   logic [7:0] i_wdata, o_rdata, rv;
   logic [15:0] period;
   logic brush_home, over_media, carriage_parked, index, unlock;
   logic o_spindle_enable, o_high_power, o_heads_extend, o_head_hold;
   logic o_head_pick, o_heads_loaded, o_unit_ready, o_brush_a, o_brush_b;
   logic o_release_tray_n;
   int n_fail = 0;
   int n_checks = 0;
   int hi;
   speed_monitor #(.BASE_CYC(5), .PARK_CYC(20), .PICK_CYC(30),
      .SWEEP_CYC(4)) u_speed_monitor (.i_mclk(i_mclk), .i_reset(i_reset),
      .i_run_sel(i_run_sel), .i_cart_present(i_cart_present),
      .i_drawer_closed(i_drawer_closed), .i_brush_home(brush_home),
      .i_over_media(over_media), .i_carriage_parked(carriage_parked),
      .i_index(index), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .o_spindle_enable(o_spindle_enable),
      .o_high_power(o_high_power), .o_heads_extend(o_heads_extend),
      .o_head_hold(o_head_hold), .o_head_pick(o_head_pick),
      .o_heads_loaded(o_heads_loaded), .o_unit_ready(o_unit_ready),
      .o_brush_a(o_brush_a), .o_brush_b(o_brush_b),
      .o_release_tray_n(o_release_tray_n));
   spindle_sensors u_spindle_sensors (.i_mclk(i_mclk), .i_reset(i_reset),
      .i_period(period), .i_media_block(media_block),
      .i_spindle_enable(o_spindle_enable), .i_heads_extend(o_heads_extend),
      .i_brush_a(o_brush_a), .i_brush_b(o_brush_b),
      .i_release_tray_n(o_release_tray_n), .o_index(index),
      .o_brush_home(brush_home), .o_over_media(over_media),
      .o_carriage_parked(carriage_parked), .o_unlock(unlock));
   initial
   begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end
   task automatic test_done();
      if (n_fail == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : chk
   task automatic chk1(input logic seen, input logic exp);
      chk({7'h00, seen}, {7'h00, exp});
   endtask : chk1
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge i_mclk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 rv = o_rdata;
   endtask : rd
   task automatic settle(input int n);
      repeat (n) @(posedge index);
      repeat (10) @(posedge i_mclk);
   endtask : settle
   task automatic t_reset();
      repeat (10) @(posedge i_mclk);
      rd(REG_STATUS);
      chk(rv, 8'h40);
      rd(REG_CTRL);
      chk(rv, CTRL_RESET);
      wr(4'h3, 8'hff);
      rd(4'h3);
      chk(rv, 8'h00);
   endtask : t_reset
   task automatic t_refuse();
      i_run_sel <= 1'b1;
      repeat (50) @(posedge i_mclk);
      chk1(o_spindle_enable, 1'b0);
      rd(REG_STATUS);
      chk1(rv[7], 1'b0);
   endtask : t_refuse
   task automatic t_start();
      period <= 16'd612;
      i_drawer_closed <= 1'b1;
      repeat (20) @(posedge i_mclk);
      chk1(o_spindle_enable, 1'b1);
      chk1(o_heads_extend, 1'b1);
      chk1(o_release_tray_n, 1'b1);
      hi = 0;
      for (int k = 0; k < 8; k++)
      begin
         @(posedge i_mclk);
         chk1(o_brush_a ^ o_brush_b, 1'b1);
         hi += int'(o_brush_a === 1'b1);
      end
      chk(8'(hi), 8'h04);
      // speed flags come good while the brushes are still out
      settle(3);
      chk1(o_head_hold, 1'b0);
      rd(REG_STATUS);
      chk(rv, 8'ha7);
      for (int k = 0; k < 5000 && brush_home !== 1'b1; k++)
         @(posedge i_mclk);
      for (int k = 0; k < 100 && o_head_hold !== 1'b1; k++)
         @(posedge i_mclk);
      repeat (15) @(posedge i_mclk);
      chk1(o_head_pick, 1'b1);
      chk1(o_heads_loaded, 1'b0);
      repeat (25) @(posedge i_mclk);
      chk1(o_head_pick, 1'b0);
      chk1(o_heads_loaded, 1'b1);
      chk1(o_unit_ready, 1'b1);
      rd(REG_STATUS);
      chk(rv, 8'h9f);
   endtask : t_start
   task automatic t_speed();
      period <= 16'd400;
      settle(3);
      rd(REG_STATUS);
      chk(rv, 8'h93);
      chk1(o_unit_ready, 1'b0);
      period <= 16'd690;
      settle(3);
      rd(REG_STATUS);
      chk(rv, 8'h81);
      chk1(o_head_hold, 1'b0);
      period <= 16'd2000;
      settle(3);
      rd(REG_COUNT);
      chk(rv, 8'h00);
      repeat (1700) @(posedge i_mclk);
      rd(REG_COUNT);
      chk(rv, CNT_STOP);
      rd(REG_STATUS);
      chk(rv, 8'h80);
      chk1(o_high_power, 1'b0);
      period <= 16'd612;
      settle(3);
      repeat (40) @(posedge i_mclk);
      rd(REG_STATUS);
      chk(rv, 8'h9f);
      media_block <= 1'b1;
      repeat (10) @(posedge i_mclk);
      chk1(o_head_hold, 1'b0);
      chk1(o_heads_loaded, 1'b0);
      media_block <= 1'b0;
      repeat (60) @(posedge i_mclk);
   endtask : t_speed
   task automatic t_low();
      wr(REG_CTRL, 8'h01);
      rd(REG_CTRL);
      chk(rv, 8'h01);
      period <= 16'd980;
      settle(3);
      rd(REG_STATUS);
      chk(rv & 8'h07, 8'h07);
      period <= 16'd612;
      settle(3);
      rd(REG_STATUS);
      chk(rv & 8'h07, 8'h03);
      wr(REG_CTRL, 8'h00);
      settle(3);
   endtask : t_low
   task automatic t_stop();
      i_run_sel <= 1'b0;
      repeat (10) @(posedge i_mclk);
      chk1(o_head_hold, 1'b0);
      chk1(o_spindle_enable, 1'b1);
      rd(REG_STATUS);
      chk(rv & 8'h9f, 8'h00);
      repeat (30) @(posedge i_mclk);
      chk1(o_spindle_enable, 1'b0);
      chk1(o_heads_extend, 1'b0);
      rd(REG_STATUS);
      chk(rv & 8'h40, 8'h40);
      repeat (150) @(posedge i_mclk);
      chk1(o_release_tray_n, 1'b0);
      chk1(unlock, 1'b1);
   endtask : t_stop
   initial
   begin
      i_reset = 1'b1;
      i_run_sel = 1'b0;
      i_cart_present = 1'b1;
      i_drawer_closed = 1'b0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 4'h0;
      i_wdata = 8'h00;
      media_block = 1'b0;
      period = 16'h0000;
      repeat (10) @(posedge i_mclk);
      i_reset <= 1'b0;
      t_reset();
      t_refuse();
      t_start();
      t_speed();
      t_low();
      t_stop();
      test_done();
   end
   initial
   begin
      #900us;
      n_fail++;
      test_done();
   end
endmodule : tb_speed_monitor
`default_nettype wire
